// ===== logic/tts_transport.v
// Purpose: transport adapter side of the tape controller interface
// Assumes: all inputs synchronous to REF_CLK; head and sensors upstream
// Notes: write data is echoed back as read-after-write check
`timescale 1ns/1ps
`include "tts_defs.vh"
module tts_transport #(
    parameter CHAR_CYCLES = `TTS_CHAR_CYCLES,
    parameter STOP_CYCLES = `TTS_STOP_CYCLES,
    parameter CNT_W = `TTS_CNT_W,
    parameter GAP_CHARS = `TTS_GAP_CHARS,
    parameter EXT_GAP_CHARS = `TTS_EXT_GAP_CHARS,
    parameter [7:0] MARK_CHAR = `TTS_MARK_CHAR
) (
    input wire REF_CLK,
    input wire RST,
    input wire [7:0] WRITE_DATA_LINES,
    input wire OP_LAUNCH_CMD,
    input wire MOVE_AHEAD_CMD,
    input wire MOVE_BACK_CMD,
    input wire REWIND_CMD,
    input wire WRITE_PERMIT_CMD,
    input wire EVEN_PARITY_SELECT,
    input wire DENSITY_SELECT_A,
    input wire DENSITY_SELECT_B,
    input wire WRITE_FILE_MARK_CMD,
    input wire EXTENDED_GAP_WRITE_CMD,
    input wire [2:0] UNIT_SELECT,
    input wire WRITE_DATA_READY,
    input wire INTERFACE_INITIALIZE,
    input wire [1:0] UNIT_ONLINE,
    input wire [1:0] UNIT_PROTECT_SENSE,
    input wire [1:0] LOAD_POINT_SENSE,
    input wire [1:0] END_POINT_SENSE,
    input wire HEAD_CHAR,
    input wire [1:0] HEAD_KIND,
    input wire [7:0] HEAD_DATA,
    input wire HEAD_PARITY,
    output reg [7:0] READ_DATA_LINES,
    output reg READ_PARITY_LINE,
    output reg MOTION_SETTLE_STATUS,
    output reg UNIT_READY_STATUS,
    output reg SELECTED_ONLINE_STATUS,
    output reg REWINDING_STATUS,
    output reg SEVEN_TRACK_STATUS,
    output reg WRITE_PROTECT_STATUS,
    output reg TAPE_START_MARKER,
    output reg TAPE_END_MARKER,
    output reg WRITE_CHAR_REQUEST,
    output reg READ_CHAR_STROBE,
    output reg FILE_MARK_DETECT,
    output reg CYCLIC_CHECK_STROBE,
    output reg LONGITUDINAL_CHECK_STROBE,
    output reg VERTICAL_PARITY_ERROR,
    output reg LONGITUDINAL_CHECK_ERROR,
    output reg CYCLIC_CHECK_ERROR
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_GAP = 3'h1;
localparam [2:0] ST_WDATA = 3'h2;
localparam [2:0] ST_WCRC = 3'h3;
localparam [2:0] ST_WLRC = 3'h4;
localparam [2:0] ST_WMARK = 3'h5;
localparam [2:0] ST_READ = 3'h6;
localparam [2:0] ST_STOP = 3'h7;

localparam [CNT_W-1:0] CHAR_LAST = CHAR_CYCLES[CNT_W-1:0] - 1'b1;
localparam [CNT_W-1:0] STOP_LAST = STOP_CYCLES[CNT_W-1:0] - 1'b1;
localparam [7:0] GAP_N = GAP_CHARS[7:0];
localparam [7:0] EXT_GAP_N = EXT_GAP_CHARS[7:0];

function unit_sel_ok;
    input [2:0] code;
    begin
        unit_sel_ok = (code == `TTS_SEL_UNIT0) || (code == `TTS_SEL_UNIT1);
    end
endfunction

function unit_bit;
    input [2:0] code;
    input [1:0] per_unit;
    begin
        unit_bit = unit_sel_ok(code) & per_unit[code[0]];
    end
endfunction

function par_bit;
    input [7:0] d;
    input even;
    begin
        par_bit = ~(^d) ^ even;
    end
endfunction

reg [2:0] state_reg;
reg [2:0] state_next;
reg [CNT_W-1:0] cnt_reg;
reg [CNT_W-1:0] cnt_next;
reg [7:0] gap_reg;
reg [7:0] gap_next;
reg [1:0] rewinding_reg;
reg [1:0] rewinding_next;
reg back_reg;
reg back_next;
reg mark_reg;
reg mark_next;
reg launch_prev_reg;

reg acc_clear;
reg acc_step;
reg [7:0] acc_char;
reg echo_en;
reg [7:0] echo_char;
reg [7:0] rd_data_next;
reg rd_par_next;
reg rds_next;
reg wrs_next;
reg cyclic_check_strobe_next;
reg longitudinal_check_strobe_next;
reg fmk_next;
reg vpe_next;
reg cyclic_check_error_next;
reg longitudinal_check_error_next;
integer i;

wire [7:0] crc_val;
wire [7:0] lrc_val;

wire online = unit_bit(UNIT_SELECT, UNIT_ONLINE);
wire protect = unit_bit(UNIT_SELECT, UNIT_PROTECT_SENSE);
wire rewinding = unit_bit(UNIT_SELECT, rewinding_reg);
wire at_load_point = unit_bit(UNIT_SELECT, LOAD_POINT_SENSE);
wire at_end_point = unit_bit(UNIT_SELECT, END_POINT_SENSE);
wire ready = (state_reg == ST_IDLE) && !rewinding && online;
// launch taken on its rising edge
wire launch_edge = OP_LAUNCH_CMD && !launch_prev_reg;
wire [2:0] dir_cmds = {MOVE_AHEAD_CMD, MOVE_BACK_CMD, REWIND_CMD};
wire one_dir = (dir_cmds == 3'h4) || (dir_cmds == 3'h2) ||
               (dir_cmds == 3'h1);
wire moving = (state_reg != ST_IDLE) && (state_reg != ST_STOP);
wire tick = moving && (cnt_reg == CHAR_LAST);

tts_check_accum u_accum (
    .clk(REF_CLK),
    .rst(RST),
    .clear(acc_clear),
    .step(acc_step),
    .char_in(acc_char),
    .crc_reg(crc_val),
    .lrc_reg(lrc_val)
);

always @* begin
    state_next = state_reg;
    gap_next = gap_reg;
    back_next = back_reg;
    mark_next = mark_reg;
    rewinding_next = rewinding_reg;
    acc_clear = 1'b0;
    acc_step = 1'b0;
    acc_char = 8'h00;
    echo_en = 1'b0;
    echo_char = 8'h00;
    rd_data_next = READ_DATA_LINES;
    rd_par_next = READ_PARITY_LINE;
    rds_next = 1'b0;
    wrs_next = 1'b0;
    cyclic_check_strobe_next = 1'b0;
    longitudinal_check_strobe_next = 1'b0;
    fmk_next = FILE_MARK_DETECT;
    vpe_next = VERTICAL_PARITY_ERROR;
    cyclic_check_error_next = CYCLIC_CHECK_ERROR;
    longitudinal_check_error_next = LONGITUDINAL_CHECK_ERROR;
    if ((moving && !tick) || (state_reg == ST_STOP)) begin
        cnt_next = cnt_reg + 1'b1;
    end else begin
        cnt_next = {CNT_W{1'b0}};
    end
    for (i = 0; i < 2; i = i + 1) begin
        if (LOAD_POINT_SENSE[i]) begin
            rewinding_next[i] = 1'b0;
        end
    end
    case (state_reg)
        ST_IDLE: begin
            if (launch_edge && ready && one_dir) begin
                acc_clear = 1'b1;
                fmk_next = 1'b0;
                vpe_next = 1'b0;
                cyclic_check_error_next = 1'b0;
                longitudinal_check_error_next = 1'b0;
                if (REWIND_CMD) begin
                    rewinding_next[UNIT_SELECT[0]] = 1'b1;
                end else if (WRITE_PERMIT_CMD) begin
                    if (MOVE_AHEAD_CMD && !protect) begin
                        state_next = ST_GAP;
                        mark_next = WRITE_FILE_MARK_CMD;
                        if (EXTENDED_GAP_WRITE_CMD) begin
                            gap_next = EXT_GAP_N;
                        end else begin
                            gap_next = GAP_N;
                        end
                    end
                end else begin
                    state_next = ST_READ;
                    back_next = MOVE_BACK_CMD;
                end
            end
        end
        ST_GAP: begin
            if (tick) begin
                if (gap_reg == 8'h00) begin
                    if (mark_reg) begin
                        state_next = ST_WMARK;
                    end else begin
                        state_next = ST_WDATA;
                        wrs_next = 1'b1;
                    end
                end else begin
                    gap_next = gap_reg - 8'h01;
                end
            end
        end
        ST_WDATA: begin
            if (tick) begin
                if (WRITE_DATA_READY) begin
                    acc_step = 1'b1;
                    acc_char = WRITE_DATA_LINES;
                    echo_en = 1'b1;
                    echo_char = WRITE_DATA_LINES;
                    wrs_next = 1'b1;
                end else begin
                    state_next = ST_WCRC;
                end
            end
        end
        ST_WCRC: begin
            if (tick) begin
                acc_step = 1'b1;
                acc_char = crc_val;
                echo_en = 1'b1;
                echo_char = crc_val;
                cyclic_check_strobe_next = 1'b1;
                state_next = ST_WLRC;
            end
        end
        ST_WMARK: begin
            if (tick) begin
                acc_step = 1'b1;
                acc_char = MARK_CHAR;
                echo_en = 1'b1;
                echo_char = MARK_CHAR;
                fmk_next = 1'b1;
                state_next = ST_WLRC;
            end
        end
        ST_WLRC: begin
            if (tick) begin
                echo_en = 1'b1;
                echo_char = lrc_val;
                longitudinal_check_strobe_next = 1'b1;
                state_next = ST_STOP;
            end
        end
        ST_READ: begin
            if (HEAD_CHAR) begin
                // flags change with the read strobe, or clear at launch or on interface initialize
                rd_data_next = HEAD_DATA;
                rd_par_next = HEAD_PARITY;
                rds_next = 1'b1;
                vpe_next = HEAD_PARITY !=
                           par_bit(HEAD_DATA, EVEN_PARITY_SELECT);
                case (HEAD_KIND)
                    `TTS_KIND_DATA: begin
                        acc_step = 1'b1;
                        acc_char = HEAD_DATA;
                    end
                    `TTS_KIND_CRC: begin
                        acc_step = 1'b1;
                        acc_char = HEAD_DATA;
                        cyclic_check_strobe_next = 1'b1;
                        cyclic_check_error_next = HEAD_DATA != crc_val;
                    end
                    `TTS_KIND_LRC: begin
                        longitudinal_check_strobe_next = 1'b1;
                        longitudinal_check_error_next = HEAD_DATA != lrc_val;
                        state_next = ST_STOP;
                    end
                    default: begin
                        acc_step = 1'b1;
                        acc_char = HEAD_DATA;
                        fmk_next = 1'b1;
                    end
                endcase
            end else if (back_reg && at_load_point) begin
                state_next = ST_STOP;
            end
        end
        default: begin
            if (cnt_reg == STOP_LAST) begin
                state_next = ST_IDLE;
                cnt_next = {CNT_W{1'b0}};
            end
        end
    endcase
    if (state_next == ST_STOP && state_reg != ST_STOP) begin
        cnt_next = {CNT_W{1'b0}};
    end
    if (echo_en) begin
        rd_data_next = echo_char;
        rd_par_next = par_bit(echo_char, EVEN_PARITY_SELECT);
        rds_next = 1'b1;
        vpe_next = 1'b0;
        cyclic_check_error_next = 1'b0;
        longitudinal_check_error_next = 1'b0;
    end
    if (INTERFACE_INITIALIZE) begin
        state_next = ST_IDLE;
        cnt_next = {CNT_W{1'b0}};
        rds_next = 1'b0;
        wrs_next = 1'b0;
        cyclic_check_strobe_next = 1'b0;
        longitudinal_check_strobe_next = 1'b0;
        fmk_next = 1'b0;
        vpe_next = 1'b0;
        cyclic_check_error_next = 1'b0;
        longitudinal_check_error_next = 1'b0;
    end
end

always @(posedge REF_CLK) begin
    if (RST) begin
        state_reg <= ST_IDLE;
        cnt_reg <= {CNT_W{1'b0}};
        gap_reg <= 8'h00;
        rewinding_reg <= 2'h0;
        back_reg <= 1'b0;
        mark_reg <= 1'b0;
        launch_prev_reg <= 1'b0;
        READ_DATA_LINES <= 8'h00;
        READ_PARITY_LINE <= 1'b0;
        MOTION_SETTLE_STATUS <= 1'b0;
        UNIT_READY_STATUS <= 1'b0;
        SELECTED_ONLINE_STATUS <= 1'b0;
        REWINDING_STATUS <= 1'b0;
        SEVEN_TRACK_STATUS <= 1'b0;
        WRITE_PROTECT_STATUS <= 1'b0;
        TAPE_START_MARKER <= 1'b0;
        TAPE_END_MARKER <= 1'b0;
        WRITE_CHAR_REQUEST <= 1'b0;
        READ_CHAR_STROBE <= 1'b0;
        FILE_MARK_DETECT <= 1'b0;
        CYCLIC_CHECK_STROBE <= 1'b0;
        LONGITUDINAL_CHECK_STROBE <= 1'b0;
        VERTICAL_PARITY_ERROR <= 1'b0;
        LONGITUDINAL_CHECK_ERROR <= 1'b0;
        CYCLIC_CHECK_ERROR <= 1'b0;
    end else begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
        gap_reg <= gap_next;
        rewinding_reg <= rewinding_next;
        back_reg <= back_next;
        mark_reg <= mark_next;
        launch_prev_reg <= OP_LAUNCH_CMD;
        READ_DATA_LINES <= rd_data_next;
        READ_PARITY_LINE <= rd_par_next;
        MOTION_SETTLE_STATUS <= state_next == ST_STOP;
        UNIT_READY_STATUS <= ready;
        SELECTED_ONLINE_STATUS <= online;
        REWINDING_STATUS <= rewinding;
        SEVEN_TRACK_STATUS <= 1'b0;
        WRITE_PROTECT_STATUS <= protect;
        TAPE_START_MARKER <= at_load_point;
        TAPE_END_MARKER <= at_end_point;
        WRITE_CHAR_REQUEST <= wrs_next;
        READ_CHAR_STROBE <= rds_next;
        FILE_MARK_DETECT <= fmk_next;
        CYCLIC_CHECK_STROBE <= cyclic_check_strobe_next;
        LONGITUDINAL_CHECK_STROBE <= longitudinal_check_strobe_next;
        VERTICAL_PARITY_ERROR <= vpe_next;
        LONGITUDINAL_CHECK_ERROR <= longitudinal_check_error_next;
        CYCLIC_CHECK_ERROR <= cyclic_check_error_next;
    end
end

endmodule

// ===== logic/tts_defs.vh
// Purpose: shared constants of the tape transport adapter logic
// Assumes: REF_CLK at 125 MHz, two transports behind one adapter
// Notes: times kept in their own units, cycle counts derived from them
`ifndef TTS_DEFS_VH
`define TTS_DEFS_VH
`define TTS_CLK_PERIOD_NS 8
`define TTS_CHAR_TIME_NS 100000
`define TTS_CHAR_CYCLES \
    ((`TTS_CHAR_TIME_NS + `TTS_CLK_PERIOD_NS - 1) / `TTS_CLK_PERIOD_NS)
`define TTS_STOP_TIME_US 30000
`define TTS_STOP_CYCLES \
    ((`TTS_STOP_TIME_US * 1000 + `TTS_CLK_PERIOD_NS - 1) / \
    `TTS_CLK_PERIOD_NS)
`define TTS_CNT_W 22
`define TTS_SEL_UNIT0 3'h0
`define TTS_SEL_UNIT1 3'h1
`define TTS_KIND_DATA 2'h0
`define TTS_KIND_CRC 2'h1
`define TTS_KIND_LRC 2'h2
`define TTS_KIND_MARK 2'h3
`define TTS_MARK_CHAR 8'h13
`define TTS_CRC_POLY 8'h07
`define TTS_GAP_CHARS 1
`define TTS_EXT_GAP_CHARS 8
`endif

// ===== logic/tts_check_accum.v
// Purpose: cyclic and longitudinal check accumulators of one record
// Assumes: one character per step pulse, clear at record start
// Notes: longitudinal value is the xor of every stepped character
`timescale 1ns/1ps
`include "tts_defs.vh"
module tts_check_accum #(
    parameter [7:0] POLY = `TTS_CRC_POLY
) (
    input wire clk,
    input wire rst,
    input wire clear,
    input wire step,
    input wire [7:0] char_in,
    output reg [7:0] crc_reg,
    output reg [7:0] lrc_reg
);

function [7:0] crc_step;
    input [7:0] crc;
    input [7:0] d;
    integer i;
    reg [7:0] c;
    begin
        c = crc;
        for (i = 0; i < 8; i = i + 1) begin
            if (c[7] ^ d[7 - i]) begin
                c = {c[6:0], 1'b0} ^ POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        crc_step = c;
    end
endfunction

always @(posedge clk) begin
    if (rst) begin
        crc_reg <= 8'h00;
        lrc_reg <= 8'h00;
    end else if (clear) begin
        crc_reg <= 8'h00;
        lrc_reg <= 8'h00;
    end else if (step) begin
        crc_reg <= crc_step(crc_reg, char_in);
        lrc_reg <= lrc_reg ^ char_in;
    end
end

endmodule

// ===== tb/tts_checker.sv
// Purpose: port-level checks of the transport adapter
// Assumes: one clock, sync reset, bound to tts_transport
// Notes: repetition counts suit the shortened character time
`timescale 1ns/1ps
module tts_checker #(
    parameter STOP_CYCLES = 20
) (
    input wire REF_CLK,
    input wire RST,
    input wire [7:0] WRITE_DATA_LINES,
    input wire OP_LAUNCH_CMD,
    input wire REWIND_CMD,
    input wire EVEN_PARITY_SELECT,
    input wire INTERFACE_INITIALIZE,
    input wire [2:0] UNIT_SELECT,
    input wire [1:0] UNIT_ONLINE,
    input wire [7:0] READ_DATA_LINES,
    input wire READ_PARITY_LINE,
    input wire MOTION_SETTLE_STATUS,
    input wire UNIT_READY_STATUS,
    input wire SELECTED_ONLINE_STATUS,
    input wire REWINDING_STATUS,
    input wire WRITE_PROTECT_STATUS,
    input wire WRITE_CHAR_REQUEST,
    input wire READ_CHAR_STROBE,
    input wire CYCLIC_CHECK_STROBE,
    input wire LONGITUDINAL_CHECK_STROBE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    reg [23:0] settle_cnt_reg;
    wire sel_on = (UNIT_SELECT == 3'h0 && UNIT_ONLINE[0]) ||
        (UNIT_SELECT == 3'h1 && UNIT_ONLINE[1]);
    wire bad_sel = UNIT_SELECT[2:1] != 2'h0;
    wire par_w = EVEN_PARITY_SELECT ? ^WRITE_DATA_LINES : ~^WRITE_DATA_LINES;
    // length of the current settle interval
    always @(posedge REF_CLK) begin
        if (RST || !MOTION_SETTLE_STATUS)
            settle_cnt_reg <= 24'h0;
        else
            settle_cnt_reg <= settle_cnt_reg + 24'h1;
    end
    ready_stop_a: assert property (UNIT_READY_STATUS |->
        !MOTION_SETTLE_STATUS && !REWINDING_STATUS) else $error("ready moving");
    online_follow_a: assert property (
        !$past(RST) && !$past(INTERFACE_INITIALIZE) |->
        SELECTED_ONLINE_STATUS == $past(sel_on)) else $error("online wrong");
    rewind_cause_a: assert property ($rose(REWINDING_STATUS) |->
        $past(REWIND_CMD, 2)) else $error("rewind without command");
    settle_len_a: assert property ($fell(MOTION_SETTLE_STATUS) |->
        settle_cnt_reg == STOP_CYCLES) else $error("settle length wrong");
    protect_nowrite_a: assert property (WRITE_PROTECT_STATUS |->
        !WRITE_CHAR_REQUEST) else $error("request while protected");
    request_pulse_a: assert property (WRITE_CHAR_REQUEST |=>
        !WRITE_CHAR_REQUEST [*4]) else $error("request not a pulse");
    echo_data_a: assert property (
        WRITE_CHAR_REQUEST && READ_CHAR_STROBE |->
        READ_DATA_LINES == $past(WRITE_DATA_LINES) &&
        READ_PARITY_LINE == $past(par_w)) else $error("echo wrong");
    cyclic_strobe_a: assert property (CYCLIC_CHECK_STROBE |->
        READ_CHAR_STROBE) else $error("cyclic strobe alone");
    longit_strobe_a: assert property (LONGITUDINAL_CHECK_STROBE |->
        READ_CHAR_STROBE && !CYCLIC_CHECK_STROBE) else $error("lrc strobe");
    launch_cause_a: assert property ($fell(UNIT_READY_STATUS) &&
        $past(SELECTED_ONLINE_STATUS) && SELECTED_ONLINE_STATUS |->
        $past(OP_LAUNCH_CMD) || $past(OP_LAUNCH_CMD, 2) ||
        $past(OP_LAUNCH_CMD, 3)) else $error("start without launch");
    bad_select_a: assert property ($past(bad_sel) |->
        !SELECTED_ONLINE_STATUS && !WRITE_PROTECT_STATUS)
        else $error("illegal select took effect");
    echo_c: cover property (WRITE_CHAR_REQUEST && READ_CHAR_STROBE);
    lrc_c: cover property (LONGITUDINAL_CHECK_STROBE);
    rewind_c: cover property ($rose(REWINDING_STATUS));
    settle_c: cover property ($fell(MOTION_SETTLE_STATUS));
endmodule

// ===== tb/tts_ctrl_model.sv
// Purpose: controller side model answering character requests
// Assumes: driven 1 ns after the clock edge
// Notes: data lines show inverted value once no character is ready
`timescale 1ns/1ps
module tts_ctrl_model (
    input wire clk,
    input wire clr,
    input wire [3:0] n_chars,
    input wire wreq,
    input wire rstb,
    input wire cstb,
    input wire lstb,
    input wire vertical_parity_error,
    input wire [7:0] rdata,
    output reg [7:0] wdata,
    output reg write_data_ready,
    output reg [3:0] n_req,
    output reg [3:0] n_rd,
    output reg [3:0] n_crc,
    output reg [3:0] n_lrc,
    output reg vpe_seen,
    output reg [7:0] last_rd
);
    // buffer bit 7 goes to line 0
    function automatic [7:0] flip(input [7:0] b);
        for (int k = 0; k < 8; k++) flip[k] = b[7 - k];
    endfunction
    initial {wdata, write_data_ready, n_req, n_rd, n_crc, n_lrc, vpe_seen, last_rd} = 0;
    always @(posedge clk) begin
        if (clr) begin
            {n_req, n_rd, n_crc, n_lrc, vpe_seen} <= 17'h0;
            write_data_ready <= #1 1'b0;
        end else begin
            if (wreq) begin
                n_req <= n_req + 4'h1;
                write_data_ready <= #1 (n_req < n_chars);
                wdata <= #1 (n_req < n_chars) ?
                    flip(8'ha0 + {4'h0, n_req}) : ~wdata;
            end
            // parity error taken at read strobe
            if (rstb) begin
                n_rd <= n_rd + 4'h1;
                last_rd <= rdata;
                vpe_seen <= vpe_seen | vertical_parity_error;
            end
            if (cstb)
                n_crc <= n_crc + 4'h1;
            if (lstb)
                n_lrc <= n_lrc + 4'h1;
        end
    end
endmodule

// ===== tb/tts_transport_test.sv
// Purpose: directed tests of the transport adapter ports
// Assumes: shortened character and stop times
// Notes: head characters are driven by the bench
`timescale 1ns/1ps
module tts_transport_test;
    localparam CHAR_CYCLES = 8;
    reg REF_CLK, RST, OP_LAUNCH_CMD, MOVE_AHEAD_CMD, REWIND_CMD, clr;
    reg WRITE_PERMIT_CMD, EVEN_PARITY_SELECT, DENSITY_SELECT_A;
    reg DENSITY_SELECT_B, WRITE_FILE_MARK_CMD, EXTENDED_GAP_WRITE_CMD;
    reg INTERFACE_INITIALIZE, HEAD_CHAR, HEAD_PARITY;
    reg [2:0] UNIT_SELECT;
    reg [1:0] UNIT_ONLINE, UNIT_PROTECT_SENSE, LOAD_POINT_SENSE, HEAD_KIND;
    reg [7:0] HEAD_DATA;
    reg [3:0] n_chars;
    wire [7:0] WRITE_DATA_LINES, READ_DATA_LINES, last_rd;
    wire [3:0] n_req, n_rd, n_crc, n_lrc;
    wire WRITE_DATA_READY, READ_PARITY_LINE, MOTION_SETTLE_STATUS, vpe_seen;
    wire UNIT_READY_STATUS, SELECTED_ONLINE_STATUS, REWINDING_STATUS;
    wire SEVEN_TRACK_STATUS, WRITE_PROTECT_STATUS, TAPE_START_MARKER;
    wire TAPE_END_MARKER, WRITE_CHAR_REQUEST, READ_CHAR_STROBE;
    wire FILE_MARK_DETECT, CYCLIC_CHECK_STROBE, LONGITUDINAL_CHECK_STROBE;
    wire VERTICAL_PARITY_ERROR, LONGITUDINAL_CHECK_ERROR, CYCLIC_CHECK_ERROR;
    integer bad_count, compares, i, j;
    tts_transport #(.CHAR_CYCLES(CHAR_CYCLES), .STOP_CYCLES(20))
        tts_transport_inst (.REF_CLK, .RST, .WRITE_DATA_LINES, .OP_LAUNCH_CMD,
        .MOVE_AHEAD_CMD, .MOVE_BACK_CMD(1'b0), .REWIND_CMD, .WRITE_PERMIT_CMD,
        .EVEN_PARITY_SELECT, .DENSITY_SELECT_A, .DENSITY_SELECT_B,
        .WRITE_FILE_MARK_CMD, .EXTENDED_GAP_WRITE_CMD, .UNIT_SELECT,
        .WRITE_DATA_READY, .INTERFACE_INITIALIZE, .UNIT_ONLINE,
        .UNIT_PROTECT_SENSE, .LOAD_POINT_SENSE, .END_POINT_SENSE(2'h0),
        .HEAD_CHAR, .HEAD_KIND, .HEAD_DATA, .HEAD_PARITY, .READ_DATA_LINES,
        .READ_PARITY_LINE, .MOTION_SETTLE_STATUS, .UNIT_READY_STATUS,
        .SELECTED_ONLINE_STATUS, .REWINDING_STATUS, .SEVEN_TRACK_STATUS,
        .WRITE_PROTECT_STATUS, .TAPE_START_MARKER, .TAPE_END_MARKER,
        .WRITE_CHAR_REQUEST, .READ_CHAR_STROBE, .FILE_MARK_DETECT,
        .CYCLIC_CHECK_STROBE, .LONGITUDINAL_CHECK_STROBE,
        .VERTICAL_PARITY_ERROR, .LONGITUDINAL_CHECK_ERROR,
        .CYCLIC_CHECK_ERROR);
    tts_ctrl_model tts_ctrl_model_inst (.clk(REF_CLK), .clr, .n_chars,
        .wreq(WRITE_CHAR_REQUEST), .rstb(READ_CHAR_STROBE),
        .cstb(CYCLIC_CHECK_STROBE), .lstb(LONGITUDINAL_CHECK_STROBE),
        .vertical_parity_error(VERTICAL_PARITY_ERROR), .rdata(READ_DATA_LINES),
        .wdata(WRITE_DATA_LINES), .write_data_ready(WRITE_DATA_READY), .n_req, .n_rd,
        .n_crc, .n_lrc, .vpe_seen, .last_rd);
    task summarize;
        begin
            $display("compares %0d bad_count %0d", compares, bad_count);
            if (bad_count == 0 && compares > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input string name, input [7:0] seen, input [7:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("mismatch %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge REF_CLK);
            #1;
        end
    endtask
    task clear_model;
        begin
            clr = 1'b1;
            tick(1);
            clr = 1'b0;
        end
    endtask
    task go(input ahead, input rew, input wp);
        begin
            {MOVE_AHEAD_CMD, REWIND_CMD, WRITE_PERMIT_CMD} = {ahead, rew, wp};
            OP_LAUNCH_CMD = 1'b1;
            tick(1);
            OP_LAUNCH_CMD = 1'b0;
            tick(3);
        end
    endtask
    task wait_ready;
        begin
            j = 0;
            while (UNIT_READY_STATUS !== 1'b1 && j < 3000) begin
                tick(1);
                j = j + 1;
            end
            chk("ready", UNIT_READY_STATUS, 1);
        end
    endtask
    task head(input [1:0] kind, input [7:0] d, input p);
        begin
            {HEAD_CHAR, HEAD_KIND, HEAD_DATA, HEAD_PARITY} = {1'b1, kind, d, p};
            tick(1);
            HEAD_CHAR = 1'b0;
            tick(CHAR_CYCLES);
        end
    endtask
    initial begin
        REF_CLK = 1'b0;
        forever #4 REF_CLK = ~REF_CLK;
    end
    initial begin
        #(8 * 6000);
        bad_count = bad_count + 1;
        summarize;
    end
    initial begin
        {OP_LAUNCH_CMD, MOVE_AHEAD_CMD, REWIND_CMD, WRITE_PERMIT_CMD,
            EVEN_PARITY_SELECT, DENSITY_SELECT_A, DENSITY_SELECT_B,
            WRITE_FILE_MARK_CMD, EXTENDED_GAP_WRITE_CMD, INTERFACE_INITIALIZE,
            HEAD_CHAR, HEAD_PARITY, UNIT_SELECT, UNIT_PROTECT_SENSE,
            LOAD_POINT_SENSE, HEAD_KIND, HEAD_DATA} = 0;
        {RST, clr, UNIT_ONLINE, n_chars, bad_count, compares} = {2'h3, 2'h1,
            4'h2, 64'h0};
        tick(12);
        {RST, clr} = 2'h0;
        tick(3);
        chk("online", SELECTED_ONLINE_STATUS, 1);
        for (i = 1; i < 8; i = i + 1) begin
            UNIT_SELECT = i;
            tick(2);
            chk("online", SELECTED_ONLINE_STATUS, 0);
        end
        {UNIT_ONLINE, UNIT_SELECT} = {2'h2, 3'h1};
        tick(2);
        chk("online", SELECTED_ONLINE_STATUS, 1);
        {UNIT_ONLINE, UNIT_SELECT} = {2'h3, 3'h0};
        tick(3);
        $display("test select done");
        {DENSITY_SELECT_A, DENSITY_SELECT_B} = 2'h3;
        go(1, 0, 0);
        chk("ready", UNIT_READY_STATUS, 0);
        head(2'h0, 8'ha5, 1'b1);
        head(2'h0, 8'h5a, 1'b0);
        head(2'h1, 8'hd8, 1'b1);
        head(2'h2, 8'h66, 1'b1);
        chk("settle", MOTION_SETTLE_STATUS, 1);
        wait_ready;
        chk("reads", n_rd, 4);
        chk("last", last_rd, 8'h66);
        chk("cyclic", n_crc, 1);
        chk("longit", n_lrc, 1);
        chk("parity", vpe_seen, 1);
        chk("crcerr", CYCLIC_CHECK_ERROR, 0);
        chk("lrcerr", LONGITUDINAL_CHECK_ERROR, 1);
        chk("seven", SEVEN_TRACK_STATUS, 0);
        $display("test read done");
        {DENSITY_SELECT_A, DENSITY_SELECT_B} = 2'h0;
        for (i = 0; i < 3; i = i + 1) begin
            clear_model;
            EVEN_PARITY_SELECT = i[0];
            EXTENDED_GAP_WRITE_CMD = (i > 0);
            WRITE_FILE_MARK_CMD = (i == 2);
            go(1, 0, 1);
            wait_ready;
            if (i < 2)
                chk("requests", n_req, 3);
            chk("reads", n_rd, (i == 2) ? 2 : 4);
            chk("cyclic", n_crc, (i == 2) ? 0 : 1);
            chk("longit", n_lrc, 1);
            chk("mark", FILE_MARK_DETECT, (i == 2));
            if (i == 2)
                chk("markchar", last_rd, 8'h13);
            $display("test write %0d done", i);
        end
        clear_model;
        UNIT_PROTECT_SENSE = 2'h1;
        go(1, 0, 1);
        tick(40);
        chk("protect", WRITE_PROTECT_STATUS, 1);
        chk("requests", n_req, 0);
        chk("reads", n_rd, 0);
        chk("ready", UNIT_READY_STATUS, 1);
        {UNIT_PROTECT_SENSE, WRITE_PERMIT_CMD} = 0;
        {EXTENDED_GAP_WRITE_CMD, WRITE_FILE_MARK_CMD} = 0;
        $display("test protect done");
        go(0, 1, 0);
        chk("rewind", REWINDING_STATUS, 1);
        chk("ready", UNIT_READY_STATUS, 0);
        LOAD_POINT_SENSE = 2'h1;
        tick(3);
        chk("rewind", REWINDING_STATUS, 0);
        chk("start", TAPE_START_MARKER, 1);
        wait_ready;
        {LOAD_POINT_SENSE, REWIND_CMD} = 0;
        $display("test rewind done");
        go(1, 0, 0);
        INTERFACE_INITIALIZE = 1'b1;
        tick(2);
        INTERFACE_INITIALIZE = 1'b0;
        tick(4);
        chk("ready", UNIT_READY_STATUS, 1);
        tick(30);
        chk("ready", UNIT_READY_STATUS, 1);
        $display("test init done");
        summarize;
    end
endmodule
bind tts_transport tts_checker #(.STOP_CYCLES(STOP_CYCLES)) tts_checker_inst (
    .REF_CLK, .RST, .WRITE_DATA_LINES, .OP_LAUNCH_CMD, .REWIND_CMD,
    .EVEN_PARITY_SELECT, .INTERFACE_INITIALIZE, .UNIT_SELECT, .UNIT_ONLINE,
    .READ_DATA_LINES, .READ_PARITY_LINE, .MOTION_SETTLE_STATUS,
    .UNIT_READY_STATUS, .SELECTED_ONLINE_STATUS, .REWINDING_STATUS,
    .WRITE_PROTECT_STATUS, .WRITE_CHAR_REQUEST, .READ_CHAR_STROBE,
    .CYCLIC_CHECK_STROBE, .LONGITUDINAL_CHECK_STROBE);
